// ===== include/cm_decode_pkg.sv
// Package: address map, field layout, reset values and carrier types
package cm_decode_pkg;

  // ---------------------------------------------------------------
  // Address map (byte addresses on the host port)
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 19;
  localparam logic [18:0] CM_LAST       = 19'h1FFFF;
  localparam logic [18:0] DM_BASE       = 19'h28000;
  localparam logic [18:0] BEREN_BASE    = 19'h30000;
  localparam logic [18:0] BAD_LO_BASE   = 19'h38000;
  localparam logic [18:0] BERCNT_BASE   = 19'h40000;
  localparam logic [18:0] GRP_BASE      = 19'h40200;
  localparam logic [18:0] GRP_LAST      = 19'h4027F;
  localparam logic [18:0] ICC_ADDR      = 19'h40280;
  localparam logic [18:0] OCC_ADDR      = 19'h40284;
  localparam logic [18:0] BI_ADDR       = 19'h40288;
  localparam logic [18:0] BIE_ADDR      = 19'h4028C;
  localparam logic [18:0] BAD_HI_BASE   = 19'h40290;
  localparam logic [11:0] RATE8_LIMIT   = 12'h800;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] GRP_RST       = 32'h000C000C;
  localparam logic [31:0] ICC_RST       = 32'h000000DB;
  localparam logic [31:0] OCC_RST       = 32'h060D1C3C;
  localparam logic [31:0] BI_RST        = 32'h00000000;
  localparam logic [31:0] BIE_RST       = 32'h00000000;
  localparam logic [31:0] CM_RST        = 32'h00000000;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int          FUNC_LSB      = 29;
  localparam int          VD_BIT        = 28;
  localparam int          ICL_LSB       = 26;
  localparam int          OCL_LSB       = 24;
  localparam int          GP_LSB        = 10;
  localparam logic [31:0] CM_WMASK      = 32'hFF007FFF;
  localparam int          OUT_RATE_LSB  = 2;
  localparam int          IN_RATE_LSB   = 18;
  localparam int          INIT_GO_BIT   = 0;
  localparam int          INIT_EN_BIT   = 0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RATE_8  = 2'h0,
    RATE_16 = 2'h1,
    RATE_32 = 2'h2,
    RATE_65 = 2'h3
  } rate_t;

  typedef enum logic [2:0] {
    FN_OFF   = 3'h0,
    FN_HIGH  = 3'h1,
    FN_MSG   = 3'h2,
    FN_VAR   = 3'h3,
    FN_CONST = 3'h4,
    FN_PSEUDO_RANDOM_PATTERN  = 3'h5
  } func_t;

  typedef enum logic [2:0] {
    K_CM   = 3'h0,
    K_GRP  = 3'h1,
    K_ICC  = 3'h2,
    K_OCC  = 3'h3,
    K_BI   = 3'h4,
    K_BIE  = 3'h5,
    K_ZERO = 3'h6
  } region_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ACCESS  = 2'b01,
    ST_RESP    = 2'b11,
    ST_RELEASE = 2'b10
  } bus_state_t;

  // Host pins bundled for the synchroniser
  typedef struct packed {
    logic        cs_n;
    logic        ds_n;
    logic        rw;
    logic [18:0] addr;
    logic [31:0] wdata;
  } host_pins_t;

  // Decoded per-channel control for the switch fabric
  typedef struct packed {
    logic [2:0]  channel_function_sel;
    logic        output_off_mode;
    logic        force_high_mode;
    logic        message_mode;
    logic        variable_delay_mode;
    logic        constant_delay_mode;
    logic        pseudo_random_pattern;
    logic        data_channel;
    logic [1:0]  input_law_sel;
    logic [1:0]  output_law_sel;
    logic [4:0]  source_group_sel;
    logic [9:0]  source_channel_sel;
    logic [1:0]  source_stream;
    logic [9:0]  source_timeslot;
    logic [7:0]  message_byte;
  } chan_ctl_t;

endpackage

// ===== rtl/cm_store.sv
// Connection memory array: one write port, two registered read ports
module cm_store #(
  parameter int DEPTH = 32768,
  parameter int WIDTH = 32,
  parameter int AW    = 15
) (
  input  wire logic             clk,
  input  wire logic             ce,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_a_en,
  input  wire logic [AW-1:0]    rd_a_addr,
  output logic      [WIDTH-1:0] rd_a_data,
  input  wire logic             rd_b_en,
  input  wire logic [AW-1:0]    rd_b_addr,
  output logic      [WIDTH-1:0] rd_b_data
);

  initial begin
    if (DEPTH > (1 << AW)) $error("cm_store: DEPTH exceeds address width");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // Write port
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Host read port, data out of a register
  always_ff @(posedge clk) begin
    if (ce && rd_a_en) begin
      rd_a_data <= mem[rd_a_addr];
    end
  end

  // Fabric read port, data out of a register
  always_ff @(posedge clk) begin
    if (ce && rd_b_en) begin
      rd_b_data <= mem[rd_b_addr];
    end
  end

endmodule

// ===== rtl/connection_memory_decode.sv
// Host port decode, connection memory and per-channel control decode
module connection_memory_decode #(
  parameter int CM_DEPTH = 32768,
  parameter int GROUPS   = 32
) (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic                        ce,
  input  wire logic                        cs_n,
  input  wire logic                        ds_n,
  input  wire logic                        rw,
  input  wire logic [18:0]                 addr,
  input  wire logic [31:0]                 d_in,
  output logic      [31:0]                 d_out,
  output logic                             d_oe_n,
  output logic                             dta_n,
  output logic                             bus_fault_signal_n,
  output logic                             wait_n,
  output logic                             init_busy,
  input  wire logic                        fab_rd,
  input  wire logic [14:0]                 fab_slot,
  output logic                             fab_valid,
  output cm_decode_pkg::chan_ctl_t         fab_ctl
);

  initial begin
    if (CM_DEPTH != 32768) $error("CM_DEPTH must be 32768");
    if (GROUPS != 32) $error("GROUPS must be 32");
  end

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  cm_decode_pkg::host_pins_t pins_raw;
  cm_decode_pkg::host_pins_t pins_s1_r;
  cm_decode_pkg::host_pins_t pins_r;

  assign pins_raw = '{cs_n: cs_n, ds_n: ds_n, rw: rw, addr: addr, wdata: d_in};

  // Two stages before any logic looks at the pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_s1_r <= '{cs_n: 1'b1, ds_n: 1'b1, rw: 1'b1, addr: '0, wdata: '0};
      pins_r    <= '{cs_n: 1'b1, ds_n: 1'b1, rw: 1'b1, addr: '0, wdata: '0};
    end else if (ce) begin
      pins_s1_r <= pins_raw;
      pins_r    <= pins_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] grp_r [GROUPS];
  logic [31:0] icc_r;
  logic [31:0] occ_r;
  logic [31:0] bi_r;
  logic [31:0] bie_r;
  logic [14:0] init_cnt_r;
  logic        init_busy_r;

  cm_decode_pkg::bus_state_t state_r;
  cm_decode_pkg::region_t    kind_r;
  logic                      err_r;
  logic [4:0]                gidx_r;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic [18:0]                a;
  logic                       is_wr;
  logic                       start;
  logic [4:0]                 grp_sel;
  logic [11:0]                cm_off;
  cm_decode_pkg::rate_t       out_rate;
  cm_decode_pkg::region_t     kind;
  logic                       err;
  logic                       cm_hit;
  logic [4:0]                 reg_grp;

  assign a       = {pins_r.addr[18:2], 2'b00};
  assign is_wr   = !pins_r.rw;
  assign start   = (state_r == cm_decode_pkg::ST_IDLE) && !pins_r.cs_n && !pins_r.ds_n
                   && !init_busy_r;
  assign grp_sel = a[16:12];
  assign cm_off  = a[11:0];
  assign reg_grp = a[6:2];
  assign out_rate = cm_decode_pkg::rate_t'(grp_r[grp_sel][cm_decode_pkg::OUT_RATE_LSB +: 2]);

  // Region and fault decision for the access being started
  always_comb begin
    kind = cm_decode_pkg::K_ZERO;
    err  = 1'b0;
    if (a <= cm_decode_pkg::CM_LAST) begin
      kind = cm_decode_pkg::K_CM;
      err  = (out_rate == cm_decode_pkg::RATE_8) &&
             (cm_off >= cm_decode_pkg::RATE8_LIMIT);
    end else if (a < cm_decode_pkg::DM_BASE) begin
      kind = cm_decode_pkg::K_ZERO;
    end else if (a < cm_decode_pkg::BEREN_BASE) begin
      err  = is_wr;
    end else if (a < cm_decode_pkg::BAD_LO_BASE) begin
      kind = cm_decode_pkg::K_ZERO;
    end else if (a < cm_decode_pkg::BERCNT_BASE) begin
      err  = 1'b1;
    end else if (a < cm_decode_pkg::GRP_BASE) begin
      kind = cm_decode_pkg::K_ZERO;
    end else if (a <= cm_decode_pkg::GRP_LAST) begin
      kind = cm_decode_pkg::K_GRP;
    end else if (a == cm_decode_pkg::ICC_ADDR) begin
      kind = cm_decode_pkg::K_ICC;
    end else if (a == cm_decode_pkg::OCC_ADDR) begin
      kind = cm_decode_pkg::K_OCC;
    end else if (a == cm_decode_pkg::BI_ADDR) begin
      kind = cm_decode_pkg::K_BI;
    end else if (a == cm_decode_pkg::BIE_ADDR) begin
      kind = cm_decode_pkg::K_BIE;
    end else begin
      err  = 1'b1;
    end
  end

  assign cm_hit = start && (kind == cm_decode_pkg::K_CM) && !err;

  // ---------------------------------------------------------------
  // Connection memory
  // ---------------------------------------------------------------
  logic        mem_we;
  logic [14:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [14:0] host_word;
  logic [31:0] host_rdata;
  logic [31:0] fab_word;

  // Group number and timeslot form a flat word index
  assign host_word = {grp_sel, cm_off[11:2]};
  assign mem_we    = init_busy_r || (cm_hit && is_wr);
  assign mem_waddr = init_busy_r ? init_cnt_r : host_word;
  assign mem_wdata = init_busy_r ? cm_decode_pkg::CM_RST
                                 : (pins_r.wdata & cm_decode_pkg::CM_WMASK);

  cm_store #(
    .DEPTH (CM_DEPTH),
    .WIDTH (32),
    .AW    (15)
  ) u_store (
    .clk       (clk),
    .ce        (ce),
    .wr_en     (mem_we),
    .wr_addr   (mem_waddr),
    .wr_data   (mem_wdata),
    .rd_a_en   (cm_hit && !is_wr),
    .rd_a_addr (host_word),
    .rd_a_data (host_rdata),
    .rd_b_en   (fab_rd),
    .rd_b_addr (fab_slot),
    .rd_b_data (fab_word)
  );

  // ---------------------------------------------------------------
  // Block initialisation
  // ---------------------------------------------------------------
  logic init_req;

  assign init_req = start && is_wr && (kind == cm_decode_pkg::K_BI) &&
                    pins_r.wdata[cm_decode_pkg::INIT_GO_BIT] &&
                    bie_r[cm_decode_pkg::INIT_EN_BIT];

  // Walk every word once, from reset or on request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      init_busy_r <= 1'b1;
      init_cnt_r  <= '0;
    end else if (ce) begin
      if (init_busy_r) begin
        init_cnt_r <= init_cnt_r + 15'h1;
        if (init_cnt_r == 15'(CM_DEPTH - 1)) begin
          init_busy_r <= 1'b0;
        end
      end else if (init_req) begin
        init_busy_r <= 1'b1;
        init_cnt_r  <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register writes
  // ---------------------------------------------------------------
  logic reg_wr;

  assign reg_wr = start && is_wr && !err;

  // Group rate registers, one per group
  generate
    for (genvar g = 0; g < GROUPS; g++) begin : g_grp
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          grp_r[g] <= cm_decode_pkg::GRP_RST;
        end else if (ce && reg_wr && (kind == cm_decode_pkg::K_GRP) &&
                     (reg_grp == 5'(g))) begin
          grp_r[g] <= pins_r.wdata;
        end
      end
    end
  endgenerate

  // Clock control and init registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      icc_r <= cm_decode_pkg::ICC_RST;
      occ_r <= cm_decode_pkg::OCC_RST;
      bi_r  <= cm_decode_pkg::BI_RST;
      bie_r <= cm_decode_pkg::BIE_RST;
    end else if (ce) begin
      if (reg_wr && (kind == cm_decode_pkg::K_ICC)) begin
        icc_r <= pins_r.wdata;
      end
      if (reg_wr && (kind == cm_decode_pkg::K_OCC)) begin
        occ_r <= pins_r.wdata;
      end
      if (reg_wr && (kind == cm_decode_pkg::K_BIE)) begin
        bie_r <= pins_r.wdata;
      end
      if (reg_wr && (kind == cm_decode_pkg::K_BI)) begin
        bi_r <= pins_r.wdata;
      end else if (!init_busy_r) begin
        bi_r[cm_decode_pkg::INIT_GO_BIT] <= 1'b0;  // Self-clears when walk ends
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus cycle sequencer
  // ---------------------------------------------------------------
  logic [31:0] reg_rdata;

  always_comb begin
    case (kind_r)
      cm_decode_pkg::K_CM:  reg_rdata = host_rdata;
      cm_decode_pkg::K_GRP: reg_rdata = grp_r[gidx_r];
      cm_decode_pkg::K_ICC: reg_rdata = icc_r;
      cm_decode_pkg::K_OCC: reg_rdata = occ_r;
      cm_decode_pkg::K_BI:  reg_rdata = bi_r;
      cm_decode_pkg::K_BIE: reg_rdata = bie_r;
      default:              reg_rdata = 32'h00000000;
    endcase
  end

  // Accept, answer with acknowledge or fault, wait for strobe release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r            <= cm_decode_pkg::ST_IDLE;
      kind_r             <= cm_decode_pkg::K_ZERO;
      err_r              <= 1'b0;
      gidx_r             <= '0;
      d_out              <= '0;
      d_oe_n             <= 1'b1;
      dta_n              <= 1'b1;
      bus_fault_signal_n <= 1'b1;
      wait_n             <= 1'b1;
    end else if (ce) begin
      case (state_r)
        cm_decode_pkg::ST_IDLE: begin
          wait_n <= !(!pins_r.cs_n && !pins_r.ds_n);  // Hold off while strobed in idle: throughout init, and one cycle at the start of each access
          if (start) begin
            kind_r  <= kind;
            err_r   <= err;
            gidx_r  <= reg_grp;
            state_r <= cm_decode_pkg::ST_ACCESS;
          end
        end
        cm_decode_pkg::ST_ACCESS: begin
          d_out              <= err_r ? 32'h00000000 : reg_rdata;
          d_oe_n             <= !pins_r.rw;
          dta_n              <= err_r;
          bus_fault_signal_n <= !err_r;
          wait_n             <= 1'b1;
          state_r            <= cm_decode_pkg::ST_RESP;
        end
        cm_decode_pkg::ST_RESP: begin
          if (pins_r.ds_n || pins_r.cs_n) begin
            dta_n              <= 1'b1;
            bus_fault_signal_n <= 1'b1;
            state_r            <= cm_decode_pkg::ST_RELEASE;
          end
        end
        cm_decode_pkg::ST_RELEASE: begin
          if (pins_r.cs_n) begin
            d_oe_n <= 1'b1;
          end
          state_r <= cm_decode_pkg::ST_IDLE;
        end
        default: begin
          state_r <= cm_decode_pkg::ST_IDLE;
        end
      endcase
      if (pins_r.cs_n && (state_r != cm_decode_pkg::ST_ACCESS)) begin
        d_oe_n <= 1'b1;  // Release data bus once deselected
      end
    end
  end

  // ---------------------------------------------------------------
  // Fabric-side control word decode
  // ---------------------------------------------------------------
  logic                      fab_pend_r;
  logic [2:0]                fn;
  logic [4:0]                sgrp;
  cm_decode_pkg::rate_t      in_rate;
  cm_decode_pkg::chan_ctl_t  ctl;

  assign fn      = fab_word[cm_decode_pkg::FUNC_LSB +: 3];
  assign sgrp    = fab_word[cm_decode_pkg::GP_LSB +: 5];
  assign in_rate = cm_decode_pkg::rate_t'(grp_r[sgrp][cm_decode_pkg::IN_RATE_LSB +: 2]);

  // Split the word into function, law, source and message fields
  always_comb begin
    ctl                       = '0;
    ctl.channel_function_sel  = fn;
    ctl.force_high_mode       = (fn == cm_decode_pkg::FN_HIGH);
    ctl.message_mode          = (fn == cm_decode_pkg::FN_MSG);
    ctl.variable_delay_mode   = (fn == cm_decode_pkg::FN_VAR);
    ctl.constant_delay_mode   = (fn == cm_decode_pkg::FN_CONST);
    ctl.pseudo_random_pattern = (fn == cm_decode_pkg::FN_PSEUDO_RANDOM_PATTERN);
    ctl.output_off_mode       = (fn == cm_decode_pkg::FN_OFF) || (fn > 3'h5);
    ctl.data_channel          = fab_word[cm_decode_pkg::VD_BIT];
    ctl.input_law_sel         = fab_word[cm_decode_pkg::ICL_LSB +: 2];
    ctl.output_law_sel        = fab_word[cm_decode_pkg::OCL_LSB +: 2];
    ctl.source_group_sel      = sgrp;
    ctl.source_channel_sel    = fab_word[9:0];
    ctl.message_byte          = fab_word[7:0];
    case (in_rate)
      cm_decode_pkg::RATE_65: begin
        ctl.source_timeslot = fab_word[9:0];
        ctl.source_stream   = 2'h0;
      end
      cm_decode_pkg::RATE_32: begin
        ctl.source_timeslot = {1'b0, fab_word[9:1]};
        ctl.source_stream   = {1'b0, fab_word[0]};
      end
      cm_decode_pkg::RATE_16: begin
        ctl.source_timeslot = {2'h0, fab_word[9:2]};
        ctl.source_stream   = fab_word[1:0];
      end
      default: begin
        ctl.source_timeslot = {3'h0, fab_word[9:3]};
        ctl.source_stream   = fab_word[1:0];
      end
    endcase
  end

  // Decoded control registered two cycles after the request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fab_pend_r <= 1'b0;
      fab_valid  <= 1'b0;
      fab_ctl    <= '0;
      init_busy  <= 1'b1;
    end else if (ce) begin
      fab_pend_r <= fab_rd;
      fab_valid  <= fab_pend_r;
      init_busy  <= init_busy_r;
      if (fab_pend_r) begin
        fab_ctl <= ctl;
      end
    end
  end

endmodule

// ===== verification/cm_decode_monitor.sv
// Concurrent checks on the host port and fabric read path
module cm_decode_monitor (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        ce,
  input wire logic        cs_n,
  input wire logic        ds_n,
  input wire logic        rw,
  input wire logic [18:0] addr,
  input wire logic [31:0] d_out,
  input wire logic        dta_n,
  input wire logic        bus_fault_signal_n,
  input wire logic        d_oe_n,
  input wire logic        wait_n,
  input wire logic        init_busy,
  input wire logic        fab_rd,
  input wire logic        fab_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Address classes
  wire logic dm  = addr >= 19'h28000 && addr <= 19'h2FFFF;
  wire logic bad = (addr >= 19'h38000 && addr <= 19'h3FFFF) || addr >= 19'h40290;
  wire logic ctl = addr >= 19'h40200 && addr <= 19'h4028F;

  one_answer_a: assert property (dta_n || bus_fault_signal_n)
    else $error("ack and fault together");
  bad_addr_a: assert property ($fell(dta_n) |-> !bad)
    else $error("ack on invalid address");
  dm_write_a: assert property ($fell(dta_n) |-> !(dm && !rw))
    else $error("ack on data memory write");
  ctl_ok_a: assert property ($fell(bus_fault_signal_n) |-> !(ctl || (dm && rw)))
    else $error("fault on valid access");
  answer_time_a: assert property ($fell(ds_n) && !cs_n && !init_busy
    |-> ##[2:6] !(dta_n && bus_fault_signal_n))
    else $error("no answer in time");
  init_quiet_a: assert property ($fell(dta_n) |-> !$past(init_busy))
    else $error("ack during init");
  fab_lat_a: assert property (fab_rd && ce |-> ##2 fab_valid)
    else $error("fabric answer late");
  fault_zero_a: assert property (!bus_fault_signal_n |-> d_out == 32'h0)
    else $error("data on fault");
  read_drive_a: assert property ($fell(dta_n) |-> d_oe_n == !rw)
    else $error("data bus drive wrong");
  wait_clear_a: assert property (!(dta_n && bus_fault_signal_n) |-> wait_n)
    else $error("wait held with answer");
endmodule

bind connection_memory_decode cm_decode_monitor u_mon (.clk, .arst_n, .ce, .cs_n, .ds_n, .rw,
  .addr, .d_out, .dta_n, .bus_fault_signal_n, .d_oe_n, .wait_n, .init_busy, .fab_rd,
  .fab_valid);

// ===== verification/cm_host_model.sv
// Host processor model on the parallel nonmultiplexed port
module cm_host_model (
  input wire logic        clk,
  input wire logic [31:0] d_out,
  input wire logic        dta_n,
  input wire logic        bus_fault_signal_n,
  output logic            cs_n,
  output logic            ds_n,
  output logic            rw,
  output logic [18:0]     addr,
  output logic [31:0]     d_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n = 1'b1;
    ds_n = 1'b1;
    rw   = 1'b1;
    addr = 19'h0;
    d_in = 32'h0;
  end

  // One word cycle; request held until the answer is sampled
  task automatic access(input logic rd_op, input logic [18:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic to);
    int n;
    @(posedge clk);
    #1;
    rw   = rd_op;
    addr = a;
    d_in = wd;
    cs_n = 1'b0;
    ds_n = 1'b0;
    n = 0;
    // Look at the answer mid-cycle, where it has settled
    while (dta_n && bus_fault_signal_n && n < 40) begin
      @(negedge clk);
      n++;
    end
    rd = d_out;
    to = n >= 40;
    @(posedge clk);
    #1;
    ds_n = 1'b1;
    cs_n = 1'b1;
    addr = ~a;
    d_in = ~wd; // Released lines do not keep the last value
    n = 0;
    while (!(dta_n && bus_fault_signal_n) && n < 40) begin
      @(negedge clk);
      n++;
    end
    to = to || n >= 40;
    repeat (2) @(posedge clk);
  endtask
endmodule

// ===== verification/connection_memory_decode_bench.sv
// Self-checking bench for the connection memory decode block
module connection_memory_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk = 1'b0;
  logic                     arst_n = 1'b0;
  logic                     fab_rd = 1'b0;
  logic [14:0]              fab_slot = 15'h0;
  logic                     cs_n, ds_n, rw, d_oe_n, dta_n, bus_fault_signal_n;
  logic                     wait_n, init_busy, fab_valid, to, ans_q = 1'b0;
  logic [18:0]              addr;
  logic [31:0]              d_in, d_out, rdata, fn;
  logic [33:0]              hn;
  cm_decode_pkg::chan_ctl_t fab_ctl;
  logic [33:0]              hq[$];
  logic [31:0]              fq[$];
  int                       failures = 0;
  int                       num_checks = 0;

  always #4 clk = ~clk;

  connection_memory_decode u_dut (.clk, .arst_n, .ce(1'b1), .cs_n, .ds_n, .rw, .addr, .d_in,
    .d_out, .d_oe_n, .dta_n, .bus_fault_signal_n, .wait_n, .init_busy, .fab_rd, .fab_slot,
    .fab_valid, .fab_ctl);
  cm_host_model u_host (.clk, .d_out, .dta_n, .bus_fault_signal_n, .cs_n, .ds_n, .rw, .addr,
    .d_in);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Note the expected answer, then run the cycle; data memory reads are not compared
  task automatic op(input logic rd, input logic f, input logic [18:0] a, input logic [31:0] v);
    hq.push_back({rd && !f && a[18:15] != 4'h5, f, v});
    u_host.access(rd, a, v, rdata, to);
    if (to) begin
      failures++;
      test_done();
    end
  endtask

  task automatic wait_init();
    for (int i = 0; i < 40000 && init_busy !== 1'b0; i++) @(posedge clk);
    if (init_busy !== 1'b0) begin
      failures++;
      test_done();
    end
  endtask

  // Compare each answer with the oldest note
  always @(negedge clk) begin
    ans_q <= !(dta_n && bus_fault_signal_n);
    if (!(dta_n && bus_fault_signal_n) && !ans_q) begin
      hn = hq.pop_front();
      check("fault", 32'(!bus_fault_signal_n), 32'(hn[32]));
      if (hn[33]) check("read data", d_out, hn[31:0]);
    end
    if (fab_valid === 1'b1) begin
      fn = fq.pop_front();
      check("modes", 32'({fab_ctl.output_off_mode, fab_ctl.force_high_mode,
        fab_ctl.message_mode, fab_ctl.variable_delay_mode, fab_ctl.constant_delay_mode,
        fab_ctl.pseudo_random_pattern}), 32'(fn[31:29] > 5 ? 6'h20 : 6'h20 >> fn[31:29]));
      check("function", 32'(fab_ctl.channel_function_sel), 32'(fn[31:29]));
      check("data", 32'(fab_ctl.data_channel), 32'(fn[28]));
      check("laws", 32'({fab_ctl.input_law_sel, fab_ctl.output_law_sel}), 32'(fn[27:24]));
      check("group", 32'(fab_ctl.source_group_sel), 32'(fn[14:10]));
      check("channel", 32'(fab_ctl.source_channel_sel), 32'(fn[9:0]));
      check("slot", 32'({fab_ctl.source_stream, fab_ctl.source_timeslot}), 32'(fn[9:0]));
      check("msg byte", 32'(fab_ctl.message_byte), 32'(fn[7:0]));
    end
  end

  // Main sequence
  initial begin
    logic [31:0] w;
    logic [31:0] wq[8];
    logic [14:0] sl[8];
    int g;
    int ts;
    void'($urandom(48));
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    wait_init();
    op(1, 0, 19'h40200, cm_decode_pkg::GRP_RST);
    op(1, 0, 19'h40280, cm_decode_pkg::ICC_RST);
    op(1, 0, 19'h40284, cm_decode_pkg::OCC_RST);
    op(1, 0, 19'h40288, cm_decode_pkg::BI_RST);
    op(1, 0, 19'h4028C, cm_decode_pkg::BIE_RST);
    op(1, 0, 19'h1FFFC, 32'h0);
    for (int k = 0; k < 8; k++) begin
      g = $urandom_range(31);
      ts = k * 128 + $urandom_range(127);
      w = {k[2:0], 29'($urandom())};
      wq[k] = w & cm_decode_pkg::CM_WMASK;
      sl[k] = 15'(g * 1024 + ts);
      op(0, 0, 19'(g * 4096 + ts * 4), w);
      op(1, 0, 19'(g * 4096 + ts * 4), wq[k]);
    end
    foreach (sl[k]) begin
      @(posedge clk);
      #1 fab_rd = 1'b1;
      fab_slot = sl[k];
      fq.push_back(wq[k]);
    end
    @(posedge clk);
    #1 fab_rd = 1'b0;
    op(0, 1, 19'h28000, w);
    op(1, 0, 19'h2FFFC, 32'h0);
    op(1, 1, 19'h38000, 32'h0);
    op(0, 1, 19'h3FFFC, w);
    op(1, 1, 19'h40290, 32'h0);
    op(0, 1, 19'h7FFFC, w);
    op(0, 0, 19'h30000, w);
    op(0, 0, 19'h40200, 32'h0);
    op(0, 0, 19'h007FC, w);
    op(0, 1, 19'h00800, w);
    op(1, 1, 19'h00FFC, 32'h0);
    op(1, 0, 19'h007FC, w & cm_decode_pkg::CM_WMASK);
    op(0, 0, 19'h4028C, 32'h1);
    op(0, 0, 19'h40288, 32'h1);
    wait_init();
    op(1, 0, 19'h007FC, 32'h0);
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
